// *** usb_host_cmd_consts.vh ***
`ifndef USB_HOST_CMD_CONSTS_VH
`define USB_HOST_CMD_CONSTS_VH

// Command codes
`define CMD_ECHO        8'h06
`define CMD_MAX_UNIT    8'h0A
`define CMD_SEL_UNIT    8'h0B
`define CMD_LINK_MODE   8'h15
`define CMD_ATTACH_Q    8'h16
`define CMD_ABORT_NAK   8'h17
`define CMD_GET_STATUS  8'h22
`define CMD_RD_BLOCK    8'h28

// Fixed key bytes
`define KEY_MAX_UNIT    8'h38
`define KEY_SEL_UNIT    8'h34
`define KEY_PPS         8'h39

// Operation results
`define RES_OK          8'h51
`define RES_FAIL        8'h5F

// Link mode codes
`define MODE_DEV_OFF    8'h00
`define MODE_DEV_EXT    8'h01
`define MODE_DEV_INT    8'h02
`define MODE_HOST_OFF   8'h04
`define MODE_HOST_NOSOF 8'h05
`define MODE_HOST_SOF   8'h06
`define MODE_HOST_RST   8'h07

// Interrupt status codes
`define ST_SUCCESS      8'h14
`define ST_CONNECT      8'h15
`define ST_DISCONNECT   8'h16
`define ST_BUF_OVER     8'h17
`define ST_RD_PEND      8'h1D
`define ST_WR_PEND      8'h1E
`define ST_STOR_FAIL    8'h1F
`define ST_FAIL_HI      1'h1
`define ST_IDLE_VAL     8'h00

// Failure cause encodings
`define CAUSE_NAK       4'hA
`define CAUSE_STALL     4'hE

// Defaults and limits
`define UNIT_RESET      8'h00
`define PPS_RESET       8'h08
`define BLK_MAX         7'h40

// Timing
`define CLK_PERIOD_NS   8
`define MODE_TIME_NS    20000
`define ATTACH_TIME_NS  2000

`endif

// *** usb_host_cmd_interpreter.v ***
`include "usb_host_cmd_consts.vh"

module usb_host_cmd_interpreter #(
  parameter [7:0] PPS_CMD   = 8'h0C,
  parameter [7:0] ST_READY  = 8'h18
) (
  // Clock, reset, enable
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire       ce,
  // Host byte port
  input  wire       wr_cmd,
  input  wire       wr_data,
  input  wire [7:0] wr_byte,
  input  wire       rd_data,
  output wire [7:0] rd_byte,
  output wire       rd_valid,
  output wire       int_n,
  // Storage side
  input  wire [7:0] max_unit,
  input  wire       storage_init_done,
  output wire [7:0] unit_sel,
  output wire [7:0] packets_per_sector,
  // Link mode controls
  output wire [7:0] link_mode,
  output wire       host_role,
  output wire       detect_en,
  output wire       sof_en,
  output wire       bus_reset,
  output wire       nak_abort,
  // Attach sensing
  input  wire       attach_pin,
  input  wire       dev_ready,
  // Transaction engine events
  input  wire       ev_success,
  input  wire       ev_buf_over,
  input  wire       ev_rd_pend,
  input  wire       ev_wr_pend,
  input  wire       ev_stor_fail,
  input  wire       ev_fail,
  input  wire       fail_toggle_ok,
  input  wire [3:0] fail_resp,
  // Endpoint input buffer
  input  wire [6:0] buf_len,
  input  wire [7:0] buf_rdata,
  output wire [5:0] buf_addr
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_P1   = 3'd1;
  localparam [2:0] S_P2   = 3'd2;
  localparam [2:0] S_WAIT = 3'd3;
  localparam [2:0] S_OUT  = 3'd4;
  localparam [2:0] S_BLK  = 3'd5;

  localparam integer MODE_CYC_I   = `MODE_TIME_NS / `CLK_PERIOD_NS;
  localparam integer ATTACH_CYC_I = `ATTACH_TIME_NS / `CLK_PERIOD_NS;
  // Both counts fit twelve bits; a faster clock needs a wider counter
  localparam [11:0]  MODE_CYC     = MODE_CYC_I[11:0];
  localparam [11:0]  ATTACH_CYC   = ATTACH_CYC_I[11:0];

  function mode_ok;
    input [7:0] m;
    begin
      mode_ok = (m == `MODE_DEV_OFF) || (m == `MODE_DEV_EXT) ||
                (m == `MODE_DEV_INT) || (m == `MODE_HOST_OFF) ||
                (m == `MODE_HOST_NOSOF) || (m == `MODE_HOST_SOF) ||
                (m == `MODE_HOST_RST);
    end
  endfunction

  function mode_detects;
    input [7:0] m;
    begin
      mode_detects = (m == `MODE_DEV_EXT) || (m == `MODE_DEV_INT) ||
                     (m == `MODE_HOST_NOSOF) || (m == `MODE_HOST_SOF) ||
                     (m == `MODE_HOST_RST);
    end
  endfunction

  reg [2:0]  state_r;
  reg [7:0]  cmd_r;
  reg [7:0]  p1_r;
  reg [11:0] cnt_r;
  reg [7:0]  out_r;
  reg        out_valid_r;
  reg [6:0]  blk_left_r;
  reg [5:0]  buf_addr_r;
  reg [7:0]  unit_r;
  reg [7:0]  pps_r;
  reg [7:0]  mode_r;
  reg [7:0]  mode_req_r;
  reg        nak_abort_r;
  reg [7:0]  status_r;
  reg        int_pend_r;
  reg        att_s1_r;
  reg        att_s2_r;
  reg        att_prev_r;

  // Event selection; one status per cycle, failures win
  reg        ev_any;
  reg [7:0]  ev_code;
  wire       att_rise = att_s2_r & ~att_prev_r;
  wire       att_fall = ~att_s2_r & att_prev_r;
  wire       det_on   = mode_detects(mode_r);

  always @* begin
    ev_any  = 1'b1;
    ev_code = `ST_IDLE_VAL;
    if (ev_fail)
      ev_code = {2'b00, `ST_FAIL_HI, fail_toggle_ok, fail_resp};
    else if (ev_stor_fail)
      ev_code = `ST_STOR_FAIL;
    else if (ev_buf_over)
      ev_code = `ST_BUF_OVER;
    else if (ev_rd_pend)
      ev_code = `ST_RD_PEND;
    else if (ev_wr_pend)
      ev_code = `ST_WR_PEND;
    else if (ev_success)
      ev_code = `ST_SUCCESS;
    else if (det_on && att_rise)
      ev_code = `ST_CONNECT;
    else if (det_on && att_fall)
      ev_code = `ST_DISCONNECT;
    else
      ev_any = 1'b0;
  end

  // Attach pin comes from off chip
  always @(posedge clk_sys) begin
    if (!nrst) begin
      att_s1_r   <= 1'b0;
      att_s2_r   <= 1'b0;
      att_prev_r <= 1'b0;
    end else if (ce) begin
      att_s1_r   <= attach_pin;
      att_s2_r   <= att_s1_r;
      att_prev_r <= att_s2_r;
    end
  end

  wire fetch = wr_cmd && (wr_byte == `CMD_GET_STATUS);

  // Status latch; a new event beats the fetch clear
  always @(posedge clk_sys) begin
    if (!nrst) begin
      status_r   <= `ST_IDLE_VAL;
      int_pend_r <= 1'b0;
    end else if (ce) begin
      if (ev_any) begin
        status_r   <= ev_code;
        int_pend_r <= 1'b1;
      end else if (fetch) begin
        int_pend_r <= 1'b0;
      end
    end
  end

  wire [7:0] attach_code = !att_s2_r ? `ST_DISCONNECT :
                           dev_ready ? ST_READY : `ST_CONNECT;
  wire [6:0] len_clip = (buf_len > `BLK_MAX) ? `BLK_MAX : buf_len;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_r     <= S_IDLE;
      cmd_r       <= 8'h00;
      p1_r        <= 8'h00;
      cnt_r       <= 12'h000;
      out_r       <= 8'h00;
      out_valid_r <= 1'b0;
      blk_left_r  <= 7'h00;
      buf_addr_r  <= 6'h00;
      unit_r      <= `UNIT_RESET;
      pps_r       <= `PPS_RESET;
      mode_r      <= `MODE_DEV_OFF;
      mode_req_r  <= 8'h00;
      nak_abort_r <= 1'b0;
    end else if (ce) begin
      nak_abort_r <= 1'b0;
      if (storage_init_done) begin
        unit_r <= `UNIT_RESET;
        pps_r  <= `PPS_RESET;
      end
      if (wr_cmd) begin
        // A new command always restarts the sequence
        cmd_r       <= wr_byte;
        out_valid_r <= 1'b0;
        state_r     <= S_IDLE;
        case (wr_byte)
          `CMD_ECHO, `CMD_MAX_UNIT, `CMD_SEL_UNIT, `CMD_LINK_MODE: begin
            state_r <= S_P1;
          end
          `CMD_ATTACH_Q: begin
            out_r       <= 8'h00;
            out_valid_r <= 1'b1;
            cnt_r       <= ATTACH_CYC;
            state_r     <= S_WAIT;
          end
          `CMD_ABORT_NAK: begin
            nak_abort_r <= 1'b1;
          end
          `CMD_GET_STATUS: begin
            out_r       <= status_r;
            out_valid_r <= 1'b1;
            state_r     <= S_OUT;
          end
          `CMD_RD_BLOCK: begin
            out_r       <= {1'b0, len_clip};
            out_valid_r <= 1'b1;
            blk_left_r  <= len_clip;
            buf_addr_r  <= 6'h00;
            state_r     <= S_BLK;
          end
          default: begin
            if (wr_byte == PPS_CMD)
              state_r <= S_P1;
          end
        endcase
      end else begin
        case (state_r)
          S_IDLE: begin
            out_valid_r <= 1'b0;
          end
          S_P1: begin
            if (wr_data) begin
              p1_r <= wr_byte;
              case (cmd_r)
                `CMD_ECHO: begin
                  out_r       <= ~wr_byte;
                  out_valid_r <= 1'b1;
                  state_r     <= S_OUT;
                end
                `CMD_MAX_UNIT: begin
                  // Key byte is not checked; the answer is the same
                  out_r       <= max_unit;
                  out_valid_r <= 1'b1;
                  state_r     <= S_OUT;
                end
                `CMD_LINK_MODE: begin
                  mode_req_r <= wr_byte;
                  cnt_r      <= MODE_CYC;
                  state_r    <= S_WAIT;
                end
                default: begin
                  state_r <= S_P2;
                end
              endcase
            end
          end
          S_P2: begin
            if (wr_data) begin
              if (cmd_r == `CMD_SEL_UNIT && p1_r == `KEY_SEL_UNIT)
                unit_r <= wr_byte;
              if (cmd_r == PPS_CMD && p1_r == `KEY_PPS)
                pps_r <= wr_byte;
              state_r <= S_IDLE;
            end
          end
          S_WAIT: begin
            if (cnt_r > 12'h001) begin
              cnt_r <= cnt_r - 12'h001;
            end else begin
              out_valid_r <= 1'b1;
              state_r     <= S_OUT;
              if (cmd_r == `CMD_ATTACH_Q) begin
                out_r <= attach_code;
              end else if (mode_ok(mode_req_r)) begin
                mode_r <= mode_req_r;
                out_r  <= `RES_OK;
              end else begin
                out_r  <= `RES_FAIL;
              end
            end
          end
          S_OUT: begin
            if (rd_data) begin
              out_valid_r <= 1'b0;
              state_r     <= S_IDLE;
            end
          end
          S_BLK: begin
            if (rd_data) begin
              if (blk_left_r == 7'h00) begin
                out_valid_r <= 1'b0;
                state_r     <= S_IDLE;
              end else begin
                out_r      <= buf_rdata;
                buf_addr_r <= buf_addr_r + 6'h01;
                blk_left_r <= blk_left_r - 7'h01;
              end
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  assign rd_byte            = out_r;
  assign rd_valid           = out_valid_r;
  assign int_n              = ~int_pend_r;
  assign unit_sel           = unit_r;
  assign packets_per_sector = pps_r;
  assign link_mode          = mode_r;
  assign host_role          = mode_r[2];
  assign detect_en          = det_on;
  assign sof_en             = (mode_r == `MODE_HOST_SOF);
  assign bus_reset          = (mode_r == `MODE_HOST_RST);
  assign nak_abort          = nak_abort_r;
  assign buf_addr           = buf_addr_r;

endmodule // usb_host_cmd_interpreter

// *** cmd_checker_sva.sv ***
module cmd_checker (
  // Clock and reset
  input wire       clk_sys,
  input wire       nrst,
  input wire       ce,
  // Host port
  input wire       wr_cmd,
  input wire       wr_data,
  input wire [7:0] wr_byte,
  input wire [7:0] rd_byte,
  input wire       rd_valid,
  input wire       int_n,
  // Storage and link
  input wire [7:0] max_unit,
  input wire       storage_init_done,
  input wire [7:0] unit_sel,
  input wire [7:0] packets_per_sector,
  input wire [7:0] link_mode,
  input wire       host_role,
  input wire       sof_en,
  input wire       bus_reset,
  input wire       nak_abort,
  // Engine events and buffer
  input wire       ev_success,
  input wire       ev_buf_over,
  input wire       ev_rd_pend,
  input wire       ev_wr_pend,
  input wire       ev_stor_fail,
  input wire       ev_fail,
  input wire [6:0] buf_len
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [7:0] cmd_r;
  wire       ev_any = ev_success | ev_buf_over | ev_rd_pend | ev_wr_pend | ev_stor_fail | ev_fail;
  wire       fetch = wr_cmd && wr_byte == 8'h22;
  // First parameter byte only: later ones see a cleared command
  always @(posedge clk_sys)
    if (!nrst)
      cmd_r <= 8'h00;
    else if (ce && wr_cmd)
      cmd_r <= wr_byte;
    else if (ce && wr_data)
      cmd_r <= 8'h00;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst || !ce);
  a_echo_invert: assert property (wr_data && cmd_r == 8'h06 |=> rd_byte == ~$past(wr_byte))
    else $error("echo answer wrong");
  a_max_unit: assert property (wr_data && cmd_r == 8'h0A |=> rd_byte == $past(max_unit))
    else $error("max unit answer wrong");
  a_init_defaults: assert property (storage_init_done && !wr_data |=>
    unit_sel == 8'h00 && packets_per_sector == 8'h08) else $error("init defaults wrong");
  a_mode_decode: assert property (sof_en == (link_mode == 8'h06) &&
    bus_reset == (link_mode == 8'h07) && host_role == link_mode[2]) else $error("mode decode");
  a_mode_result: assert property ($changed(link_mode) |-> rd_valid && rd_byte == 8'h51)
    else $error("mode changed without success result");
  a_event_int: assert property (ev_success |=> !int_n)
    else $error("event did not raise interrupt");
  a_int_hold: assert property (!int_n && !fetch |=> !int_n)
    else $error("interrupt dropped without fetch");
  a_fetch_clear: assert property (fetch && !ev_any |=> int_n && rd_valid)
    else $error("fetch did not clear interrupt");
  a_block_len: assert property (wr_cmd && wr_byte == 8'h28 |=> rd_byte == {1'h0, $past(buf_len)})
    else $error("block length wrong");
  a_nak_pulse: assert property (wr_cmd && wr_byte == 8'h17 |=> nak_abort ##1 !nak_abort)
    else $error("retry cancel pulse wrong");
endmodule // cmd_checker

// *** ep_buffer_model.sv ***
module ep_buffer_model (
  // Buffer lookup
  input  wire [5:0] buf_addr,
  input  wire [6:0] len_set,
  output wire [6:0] buf_len,
  output wire [7:0] buf_rdata,
  // Storage side
  output wire [7:0] max_unit
);
  timeunit 1ns;
  timeprecision 1ps;
  // One packet at most, whatever the bench asks
  assign buf_len   = len_set > 7'h40 ? 7'h40 : len_set;
  assign buf_rdata = 8'hA5 ^ {2'h0, buf_addr};
  assign max_unit  = 8'h03;
endmodule // ep_buffer_model

// *** usb_host_cmd_interpreter_bench.sv ***
module usb_host_cmd_interpreter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, nrst = 1'h0, ce = 1'h1, wr_cmd = 1'h0, wr_data = 1'h0, rd_data = 1'h0;
  logic storage_init_done = 1'h0, attach_pin = 1'h0, dev_ready = 1'h0, fail_toggle_ok = 1'h0;
  logic [7:0] wr_byte = 8'h00;
  logic [5:0] ev = 6'h00;
  logic [3:0] fail_resp = 4'h0;
  logic [6:0] len_set = 7'h00;
  wire  [7:0] rd_byte, unit_sel, packets_per_sector, link_mode, max_unit, buf_rdata;
  wire        rd_valid, int_n, host_role, detect_en, sof_en, bus_reset, nak_abort;
  wire  [6:0] buf_len;
  wire  [5:0] buf_addr;
  wire        ev_success = ev[0], ev_buf_over = ev[1], ev_rd_pend = ev[2];
  wire        ev_wr_pend = ev[3], ev_stor_fail = ev[4], ev_fail = ev[5];
  int         num_errors = 0, num_checks = 0, waited;
  always #4 clk_sys = ~clk_sys;
  usb_host_cmd_interpreter DUT (.clk_sys, .nrst, .ce, .wr_cmd, .wr_data, .wr_byte, .rd_data,
    .rd_byte, .rd_valid, .int_n, .max_unit, .storage_init_done, .unit_sel, .packets_per_sector,
    .link_mode, .host_role, .detect_en, .sof_en, .bus_reset, .nak_abort, .attach_pin, .dev_ready,
    .ev_success, .ev_buf_over, .ev_rd_pend, .ev_wr_pend, .ev_stor_fail, .ev_fail, .fail_toggle_ok,
    .fail_resp, .buf_len, .buf_rdata, .buf_addr);
  ep_buffer_model partner (.buf_addr, .len_set, .buf_len, .buf_rdata, .max_unit);
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Every byte is its own one-cycle pulse, launched on an edge
  task automatic put(input logic c, input logic [7:0] b);
    @(posedge clk_sys);
    wr_cmd  <= c;
    wr_data <= !c;
    wr_byte <= b;
    @(posedge clk_sys);
    wr_cmd  <= 1'h0;
    wr_data <= 1'h0;
    #1;
  endtask
  task automatic rd;
    @(posedge clk_sys);
    rd_data <= 1'h1;
    @(posedge clk_sys);
    rd_data <= 1'h0;
    #1;
  endtask
  task automatic wait_ans(input int n);
    waited = 0;
    while (!(rd_valid === 1'h1 && rd_byte !== 8'h00) && waited < n) begin
      @(posedge clk_sys);
      #1;
      waited++;
    end
  endtask
  task automatic echo;
    logic [7:0] v [2] = '{8'h57, 8'hFF};
    foreach (v[i]) begin
      put(1'h1, 8'h06);
      put(1'h0, v[i]);
      chk("echo", rd_byte, ~v[i]);
      chk("echo_valid", rd_valid, 1'h1);
      rd;
      chk("echo_done", rd_valid, 1'h0);
    end
  endtask
  task automatic units;
    put(1'h1, 8'h0A);
    put(1'h0, 8'h38);
    chk("max_unit", rd_byte, 8'h03);
    put(1'h1, 8'h0B);
    put(1'h0, 8'h34);
    put(1'h0, 8'h05);
    chk("unit", unit_sel, 8'h05);
    put(1'h1, 8'h0B);
    put(1'h0, 8'h33);
    put(1'h0, 8'h07);
    chk("unit_bad_key", unit_sel, 8'h05);
    put(1'h1, 8'h0C);
    put(1'h0, 8'h39);
    put(1'h0, 8'h20);
    chk("pps", packets_per_sector, 8'h20);
    put(1'h1, 8'h0C);
    put(1'h0, 8'h3A);
    put(1'h0, 8'h10);
    chk("pps_bad_key", packets_per_sector, 8'h20);
    @(posedge clk_sys);
    storage_init_done <= 1'h1;
    @(posedge clk_sys);
    storage_init_done <= 1'h0;
    #1;
    chk("unit_init", unit_sel, 8'h00);
    chk("pps_init", packets_per_sector, 8'h08);
  endtask
  task automatic blk(input logic [6:0] n);
    @(posedge clk_sys);
    len_set <= n;
    put(1'h1, 8'h28);
    chk("blk_len", rd_byte, {1'h0, n});
    for (int k = 0; k < n; k++) begin
      rd;
      chk("blk_data", rd_byte, 8'hA5 ^ k[7:0]);
    end
    rd;
    chk("blk_end", rd_valid, 1'h0);
  endtask
  task automatic modes;
    logic [7:0] m [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h03};
    logic [7:0] e;
    foreach (m[i]) begin
      e = i < 7 ? m[i] : 8'h07;
      put(1'h1, 8'h15);
      put(1'h0, m[i]);
      wait_ans(3000);
      chk("mode_result", rd_byte, i < 7 ? 8'h51 : 8'h5F);
      chk("mode_time", waited <= 2500, 1'h1);
      chk("mode", link_mode, e);
      chk("host", host_role, e[2]);
      chk("detect", detect_en, e inside {8'h01, 8'h02, 8'h05, 8'h06, 8'h07});
      chk("sof", sof_en, e == 8'h06);
      chk("bus_reset", bus_reset, e == 8'h07);
      rd;
    end
  endtask
  task automatic query(input logic [7:0] e);
    put(1'h1, 8'h16);
    chk("query_wait", rd_byte, 8'h00);
    wait_ans(300);
    chk("query", rd_byte, e);
    chk("query_time", waited <= 250, 1'h1);
    rd;
  endtask
  task automatic plug(input logic p, input logic [7:0] e);
    @(posedge clk_sys);
    attach_pin <= p;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("plug_int", int_n, 1'h0);
    put(1'h1, 8'h22);
    chk("plug_status", rd_byte, e);
    chk("plug_clear", int_n, 1'h1);
    rd;
  endtask
  task automatic events;
    logic [7:0] e [8] = '{8'h14, 8'h17, 8'h1D, 8'h1E, 8'h1F, 8'h3A, 8'h2E, 8'h30};
    foreach (e[i]) begin
      @(posedge clk_sys);
      ev <= 6'h01 << (i < 5 ? i : 5);
      fail_toggle_ok <= e[i][4];
      fail_resp <= e[i][3:0];
      @(posedge clk_sys);
      ev <= 6'h00;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("event_int", int_n, 1'h0);
      put(1'h1, 8'h22);
      chk("status", rd_byte, e[i]);
      chk("status_clear", int_n, 1'h1);
      rd;
    end
  endtask
  // Enable low must hold the pending status through a fetch attempt
  task automatic frozen;
    @(posedge clk_sys);
    ev <= 6'h01;
    @(posedge clk_sys);
    ev <= 6'h00;
    ce <= 1'h0;
    put(1'h1, 8'h22);
    chk("frozen_int", int_n, 1'h0);
    chk("frozen_valid", rd_valid, 1'h0);
    @(posedge clk_sys);
    ce <= 1'h1;
    put(1'h1, 8'h22);
    chk("thawed", rd_byte, 8'h14);
    chk("thawed_int", int_n, 1'h1);
    rd;
  endtask
  task automatic test_done;
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    #1;
    chk("rst_valid", rd_valid, 1'h0);
    chk("rst_int", int_n, 1'h1);
    chk("rst_mode", link_mode, 8'h00);
    echo;
    units;
    put(1'h1, 8'h17);
    chk("nak_abort", nak_abort, 1'h1);
    blk(7'h00);
    blk(7'h03);
    blk(7'h40);
    modes;
    plug(1'h1, 8'h15);
    query(8'h15);
    @(posedge clk_sys);
    dev_ready <= 1'h1;
    query(8'h18);
    plug(1'h0, 8'h16);
    query(8'h16);
    events;
    frozen;
    test_done;
  end
  // Whole run is near 21000 cycles; this leaves a wide margin
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    test_done;
  end
endmodule // usb_host_cmd_interpreter_bench
bind usb_host_cmd_interpreter cmd_checker checker_i (.clk_sys, .nrst, .ce, .wr_cmd, .wr_data,
  .wr_byte, .rd_byte, .rd_valid, .int_n, .max_unit, .storage_init_done, .unit_sel,
  .packets_per_sector, .link_mode, .host_role, .sof_en, .bus_reset, .nak_abort, .ev_success,
  .ev_buf_over, .ev_rd_pend, .ev_wr_pend, .ev_stor_fail, .ev_fail, .buf_len);
